// ==== pkg/tre_pkg.sv ====
package tre_pkg;

    // Clock period of the sequencer logic
    localparam int CLK_PERIOD_NS      = 5;

    // Timebase period with the nominal timing capacitor (130 us per nF, 10 nF)
    localparam int TB_PERIOD_NS       = 1300000;
    localparam int TB_CYCLES          = TB_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TB_CHARGE_CYCLES   = TB_CYCLES / 2;
    localparam int TB_DISCHG_CYCLES   = TB_CYCLES - TB_CHARGE_CYCLES;

    // Timebase phase counter width
    localparam int TB_CNT_W           = 20;

    // Delays counted in timebase charge starts
    localparam int TICK_W             = 4;
    localparam logic [TICK_W-1:0] FIRST_DELAY_TICKS = 4'ha;   // first_up_delay, first_down_delay: 9 to 10 periods
    localparam logic [TICK_W-1:0] STAGE_DELAY_TICKS = 4'h8;   // remaining up and down delays: 8 periods

    // Number of rail outputs
    localparam int NUM_RAILS          = 3;

    // Reset value of the pull-down enables at normal polarity: all rails pulled low
    localparam logic [NUM_RAILS-1:0] OE_RESET = 3'h7;

    // Sequencer states
    typedef enum logic [2:0] {
        TRE_IDLE = 3'b000,
        TRE_UP1  = 3'b001,
        TRE_UP2  = 3'b010,
        TRE_UP3  = 3'b011,
        TRE_ON   = 3'b100,
        TRE_DN3  = 3'b101,
        TRE_DN2  = 3'b110,
        TRE_DN1  = 3'b111
    } tre_state_e;

endpackage

// ==== hdl/tre_sequencer.sv ====
// Operation
// RQ1: After reset every rail output stays inactive until sequence enable is first seen asserted.
// RQ2: The first rail becomes active nine to ten timebase periods after sequence enable is asserted.
// RQ3: After the first rail goes active a new count aligned to a charge start activates the second rail after eight periods.
// RQ4: The third rail becomes active exactly eight timebase periods after the second.
// RQ5: When enable drops after full power-up the third rail goes inactive after the nine to ten period first delay.
// RQ6: The second and then the first rail go inactive, each eight timebase periods after the previous one.
// RQ7: The power-up count starts on the enable rising edge and restarts with all outputs inactive if enable drops before rail one.
// RQ8: Enable dropping after rail one is active but before power-up completes starts a reverse-order controlled shutdown.
// RQ9: Each rail output is open drain, released when active and pulled low when inactive at normal polarity.
// RQ10: Polarity select high makes every rail output active low, inverting the drive sense in both sequences.
// RQ11: Each timebase period is a charge phase followed at once by a discharge phase, running freely.
// RQ12: Sequence enable is synchronised before use and its rising edge is taken from the synchronised value.
module tre_sequencer
    import tre_pkg::*;
#(
    parameter int CHARGE_CYCLES = tre_pkg::TB_CHARGE_CYCLES,
    parameter int DISCHG_CYCLES = tre_pkg::TB_DISCHG_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control inputs
    input  wire logic seq_enable,
    input  wire logic polarity_select,
    // Open-drain rail outputs
    output logic      rail_out_first_o,
    output logic      rail_out_first_oe,
    output logic      rail_out_second_o,
    output logic      rail_out_second_oe,
    output logic      rail_out_third_o,
    output logic      rail_out_third_oe
);
    import tre_pkg::*;

    // Last count of each timebase phase
    localparam logic [TB_CNT_W-1:0] CHARGE_LAST = TB_CNT_W'(CHARGE_CYCLES - 1);
    localparam logic [TB_CNT_W-1:0] DISCHG_LAST = TB_CNT_W'(DISCHG_CYCLES - 1);

    // Timebase, synchroniser, sequencer and output state
    logic                  phase_q, phase_d;        // 0 charge, 1 discharge
    logic [TB_CNT_W-1:0]   tb_cnt_q, tb_cnt_d;
    logic                  charge_start_q, charge_start_d;
    logic                  en_meta_q, en_sync_q, en_prev_q;
    logic                  en_rise;
    tre_state_e            state_q, state_d;
    logic [TICK_W-1:0]     tick_q, tick_d;
    logic [NUM_RAILS-1:0]  rail_on_q, rail_on_d;
    logic [NUM_RAILS-1:0]  oe_q, oe_d;
    logic [NUM_RAILS-1:0]  lvl_q, lvl_d;

    // Free-running timebase: charge then discharge, charge start pulse on each new period after the first
    // Period is CHARGE_CYCLES plus DISCHG_CYCLES clocks, first charge starts at reset release
    always_comb begin
        phase_d        = phase_q;
        tb_cnt_d       = tb_cnt_q + TB_CNT_W'(1);
        charge_start_d = 1'b0;
        if (!phase_q && tb_cnt_q == CHARGE_LAST) begin
            phase_d  = 1'b1;                          // [RQ11]
            tb_cnt_d = '0;
        end else if (phase_q && tb_cnt_q == DISCHG_LAST) begin
            phase_d        = 1'b0;                    // [RQ11]
            tb_cnt_d       = '0;
            charge_start_d = 1'b1;
        end
    end

    // Timebase registers
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q        <= 1'b0;
            tb_cnt_q       <= '0;
            charge_start_q <= 1'b0;
        end else begin
            phase_q        <= phase_d;
            tb_cnt_q       <= tb_cnt_d;
            charge_start_q <= charge_start_d;
        end
    end

    // Enable synchroniser and edge history
    // Two flops guard against a slow comparator edge; only the second one is read
    always_ff @(posedge clk) begin
        if (rst) begin
            en_meta_q <= 1'b0;
            en_sync_q <= 1'b0;
            en_prev_q <= 1'b0;
        end else begin
            en_meta_q <= seq_enable;                  // [RQ12]
            en_sync_q <= en_meta_q;
            en_prev_q <= en_sync_q;
        end
    end

    // Rising edge of the synchronised enable
    assign en_rise = en_sync_q & ~en_prev_q;          // [RQ12]

    // Sequencer: counts charge starts, moves rails up and down
    // A charge start on the edge that leaves idle is not counted, which gives the nine to ten period spread
    always_comb begin
        state_d   = state_q;
        tick_d    = tick_q;
        rail_on_d = rail_on_q;
        if (charge_start_q) begin
            tick_d = tick_q + TICK_W'(1);
        end
        unique case (state_q)
            TRE_IDLE: begin
                rail_on_d = '0;                       // [RQ1]
                if (en_rise) begin
                    state_d = TRE_UP1;                // [RQ7]
                    tick_d  = '0;
                end
            end
            TRE_UP1: begin
                // Enable lost before rail one: drop back with no rail active
                if (!en_sync_q) begin
                    state_d = TRE_IDLE;               // [RQ7]
                    tick_d  = '0;
                end else if (charge_start_q && tick_q == FIRST_DELAY_TICKS - TICK_W'(1)) begin
                    rail_on_d[0] = 1'b1;              // [RQ2]
                    state_d      = TRE_UP2;
                    tick_d       = '0;                // [RQ3]
                end
            end
            TRE_UP2: begin
                // Enable lost here walks the full reverse sequence
                if (!en_sync_q) begin
                    state_d = TRE_DN3;                // [RQ8]
                    tick_d  = '0;
                end else if (charge_start_q && tick_q == STAGE_DELAY_TICKS - TICK_W'(1)) begin
                    rail_on_d[1] = 1'b1;              // [RQ3]
                    state_d      = TRE_UP3;
                    tick_d       = '0;
                end
            end
            TRE_UP3: begin
                // Same abandon path as the second stage
                if (!en_sync_q) begin
                    state_d = TRE_DN3;                // [RQ8]
                    tick_d  = '0;
                end else if (charge_start_q && tick_q == STAGE_DELAY_TICKS - TICK_W'(1)) begin
                    rail_on_d[2] = 1'b1;              // [RQ4]
                    state_d      = TRE_ON;
                    tick_d       = '0;
                end
            end
            TRE_ON: begin
                // Hold the count clear so the first down delay starts from zero
                tick_d = '0;
                if (!en_sync_q) begin
                    state_d = TRE_DN3;                // [RQ5]
                end
            end
            TRE_DN3: begin
                // Rails that never came up simply stay inactive on the way down
                if (charge_start_q && tick_q == FIRST_DELAY_TICKS - TICK_W'(1)) begin
                    rail_on_d[2] = 1'b0;              // [RQ5]
                    state_d      = TRE_DN2;
                    tick_d       = '0;
                end
            end
            TRE_DN2: begin
                if (charge_start_q && tick_q == STAGE_DELAY_TICKS - TICK_W'(1)) begin
                    rail_on_d[1] = 1'b0;              // [RQ6]
                    state_d      = TRE_DN1;
                    tick_d       = '0;
                end
            end
            TRE_DN1: begin
                // Last step: rail one off, then wait for a fresh enable rise
                if (charge_start_q && tick_q == STAGE_DELAY_TICKS - TICK_W'(1)) begin
                    rail_on_d[0] = 1'b0;              // [RQ6]
                    state_d      = TRE_IDLE;
                    tick_d       = '0;
                end
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q   <= TRE_IDLE;
            tick_q    <= '0;
            rail_on_q <= '0;                          // [RQ1]
        end else begin
            state_q   <= state_d;
            tick_q    <= tick_d;
            rail_on_q <= rail_on_d;
        end
    end

    // Pull-down enable per rail: released when active at normal polarity, inverted by polarity select
    genvar gi;
    generate
        for (gi = 0; gi < NUM_RAILS; gi++) begin : g_rail
            always_comb begin
                oe_d[gi]  = ~(rail_on_q[gi] ^ polarity_select);  // [RQ9] [RQ10]
                lvl_d[gi] = 1'b0;                                // Open drain only ever drives low [RQ9]
            end
        end
    endgenerate

    // Output registers; the reset value follows the polarity so no rail looks active in reset
    always_ff @(posedge clk) begin
        if (rst) begin
            oe_q  <= OE_RESET ^ {NUM_RAILS{polarity_select}};   // [RQ1] [RQ10]
            lvl_q <= '0;
        end else begin
            oe_q  <= oe_d;
            lvl_q <= lvl_d;
        end
    end

    // Pin drive straight from the output registers
    assign rail_out_first_o   = lvl_q[0];
    assign rail_out_first_oe  = oe_q[0];
    assign rail_out_second_o  = lvl_q[1];
    assign rail_out_second_oe = oe_q[1];
    assign rail_out_third_o   = lvl_q[2];
    assign rail_out_third_oe  = oe_q[2];

endmodule // tre_sequencer

// ==== dv/tre_supply_model.sv ====
// Enable pins of the three supplies, each with a pull-up resistor
module tre_supply_model (
    // Open-drain drive from the sequencer
    input  wire logic [2:0] oe,
    input  wire logic [2:0] o,
    // Level seen at each supply enable pin
    output logic      [2:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pin floats up to the pull-up level
    assign pin = (oe & o) | ~oe;
endmodule // tre_supply_model

// ==== dv/tre_props.sv ====
module tre_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control inputs
    input wire logic seq_enable,
    input wire logic polarity_select,
    // Rail outputs
    input wire logic rail_out_first_o,
    input wire logic rail_out_first_oe,
    input wire logic rail_out_second_o,
    input wire logic rail_out_second_oe,
    input wire logic rail_out_third_o,
    input wire logic rail_out_third_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] rst_sh_q;
    logic [7:0] up_cnt_q;
    logic [7:0] dn_cnt_q;
    logic       seen_q;
    logic       pol_q;
    logic       a1, a2, a3;
    // A rail is active when its pull-down matches the polarity it was registered with
    assign a1 = (rail_out_first_oe == pol_q);
    assign a2 = (rail_out_second_oe == pol_q);
    assign a3 = (rail_out_third_oe == pol_q);
    // Reset trail and cycles spent at each enable level
    always_ff @(posedge clk) begin
        rst_sh_q <= {rst_sh_q[0], rst};
        pol_q    <= polarity_select;
        seen_q   <= !rst && (seen_q || seq_enable);
        up_cnt_q <= seq_enable ? up_cnt_q + {7'h00, up_cnt_q != 8'hff} : 8'h00;
        dn_cnt_q <= !seq_enable ? dn_cnt_q + {7'h00, dn_cnt_q != 8'hff} : 8'h00;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || rst_sh_q != 2'b00);
    // One down step later the next rail drops
    sequence s_step_fall(x);
        ##32 $fell(x);
    endsequence
    chk_drive_low: assert property (!rail_out_first_o && !rail_out_second_o && !rail_out_third_o)
        else $error("rail drive level not low");
    chk_quiet_start: assert property (!seen_q |-> !a1 && !a2 && !a3)
        else $error("rail active before enable");
    chk_first_up: assert property ($rose(a1) |-> up_cnt_q inside {[34:47]})
        else $error("first rail up delay wrong");
    chk_up_gap2: assert property ($rose(a2) |-> $past(a1, 32) && !$past(a1, 33))
        else $error("second rail up gap wrong");
    chk_up_gap3: assert property ($rose(a3) |-> $past(a2, 32) && !$past(a2, 33))
        else $error("third rail up gap wrong");
    chk_first_down: assert property ($fell(a3) |-> dn_cnt_q inside {[34:47]})
        else $error("third rail down delay wrong");
    chk_down_gap2: assert property ($fell(a3) |-> s_step_fall(a2))
        else $error("second rail down gap wrong");
    chk_down_gap1: assert property ($fell(a2) |-> s_step_fall(a1))
        else $error("first rail down gap wrong");
    chk_down_order: assert property ($fell(a1) |-> !a2 && !a3)
        else $error("first rail dropped before later rails");
endmodule // tre_props

bind tre_sequencer tre_props u_props (.clk(clk), .rst(rst), .seq_enable(seq_enable),
    .polarity_select(polarity_select), .rail_out_first_o(rail_out_first_o),
    .rail_out_first_oe(rail_out_first_oe), .rail_out_second_o(rail_out_second_o),
    .rail_out_second_oe(rail_out_second_oe), .rail_out_third_o(rail_out_third_o),
    .rail_out_third_oe(rail_out_third_oe));

// ==== dv/three_rail_enable_sequencer_bench.sv ====
module three_rail_enable_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tre_pkg::*;
    `define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
        $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
    logic       clk, rst, seq_enable, polarity_select;
    logic [2:0] oe, o, pin;
    int         err_count = 0;
    int         num_checks = 0;
    // Short timebase: period of four clocks
    tre_sequencer #(.CHARGE_CYCLES(2), .DISCHG_CYCLES(2)) dut (.clk(clk), .rst(rst), .seq_enable(seq_enable),
        .polarity_select(polarity_select), .rail_out_first_o(o[0]), .rail_out_first_oe(oe[0]),
        .rail_out_second_o(o[1]), .rail_out_second_oe(oe[1]), .rail_out_third_o(o[2]), .rail_out_third_oe(oe[2]));
    tre_supply_model u_model (.oe(oe), .o(o), .pin(pin));
    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Wait for a pin level, then check elapsed cycles and all pins
    task automatic step(input int i, input logic lvl, input int lo, input int hi, input logic [2:0] ev);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pin[i] !== lvl && n < 300);
        `CHK("delay", 1'b1, n >= lo && n <= hi)
        `CHK("rails", ev, pin)
    endtask
    task automatic t_full(input logic pol);
        polarity_select <= pol;
        repeat (4) @(posedge clk);
        `CHK("idle", {3{pol}}, pin)
        seq_enable <= 1'b1;
        step(0, ~pol, 36, 47, {pol, pol, ~pol});
        step(1, ~pol, 32, 32, {pol, ~pol, ~pol});
        step(2, ~pol, 32, 32, {3{~pol}});
        seq_enable <= 1'b0;
        step(2, pol, 36, 47, {pol, ~pol, ~pol});
        step(1, pol, 32, 32, {pol, pol, ~pol});
        step(0, pol, 32, 32, {3{pol}});
    endtask
    task automatic t_glitch;
        polarity_select <= 1'b0;
        seq_enable <= 1'b1;
        repeat (20) @(posedge clk);
        seq_enable <= 1'b0;
        repeat (60) @(posedge clk);
        `CHK("glitch", 3'h0, pin)
    endtask
    task automatic t_abort;
        seq_enable <= 1'b1;
        step(0, 1'b1, 36, 47, 3'h1);
        repeat (10) @(posedge clk);
        seq_enable <= 1'b0;
        step(0, 1'b0, 100, 111, 3'h0);
    endtask
    // Mid-run reset with inverted polarity: rails must read inactive in reset and 100 cycles after release
    task automatic t_reset;
        polarity_select <= 1'b1;
        rst             <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("in reset", 3'h7, pin)
        rst <= 1'b0;
        repeat (100) @(posedge clk);
        `CHK("after reset", 3'h7, pin)
        polarity_select <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        seq_enable = 1'b0;
        polarity_select = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (100) @(posedge clk);
        `CHK("quiet", 3'h0, pin)
        t_full(1'b0);
        t_full(1'b1);
        t_glitch();
        t_full(1'b0);
        t_abort();
        t_reset();
        summarize();
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule // three_rail_enable_sequencer_bench
